// >>> shared/psrcfg_pkg.sv
package psrcfg_pkg;

  // ==========================================================
  // clock and timing
  // ==========================================================
  localparam int CLK_MHZ          = 40;
  localparam int DPD_EXIT_US      = 10;
  localparam int INIT_US          = 150;
  // least times: whole microseconds times an integer rate are exact
  localparam int DPD_EXIT_CYCLES  = DPD_EXIT_US * CLK_MHZ;
  localparam int INIT_CYCLES      = INIT_US * CLK_MHZ;
  localparam int PWR_CNT_W        = 13;

  // ==========================================================
  // register selection
  // ==========================================================
  localparam logic [1:0]  SEL_REFRESH   = 2'b00;
  localparam logic [1:0]  SEL_IDENT     = 2'b01;
  localparam logic [1:0]  SEL_BUS       = 2'b10;
  localparam logic [15:0] SW_CODE_REFRESH = 16'h0000;
  localparam logic [15:0] SW_CODE_IDENT   = 16'h0002;
  localparam logic [15:0] SW_CODE_BUS     = 16'h0001;

  // ==========================================================
  // bus configuration fields
  // ==========================================================
  localparam logic [15:0] BUS_CFG_RESET  = 16'h9D1F;
  localparam int          BUS_DRIVE_BIT  = 4;
  localparam int          BUS_WAIT_EARLY = 8;
  localparam int          BUS_WAIT_POL   = 10;
  localparam int          BUS_LAT_LSB    = 11;
  localparam int          BUS_LAT_MSB    = 13;
  localparam int          BUS_LAT_FIXED  = 14;
  localparam int          BUS_MODE_BIT   = 15;
  localparam logic        MODE_ASYNC     = 1'b1;
  localparam logic [3:0]  LAT_CODE0_VAL  = 4'h8;

  // ==========================================================
  // refresh configuration fields
  // ==========================================================
  localparam logic [15:0] REFRESH_CFG_RESET = 16'h0010;
  localparam int          REFRESH_PWR_BIT   = 4;
  localparam int          PAR_MSB           = 2;
  localparam logic [20:0] ARRAY_LAST        = 21'h1FFFFF;

  // ==========================================================
  // identification fields (all values arbitrary, neutral)
  // ==========================================================
  localparam logic       ID_ROW_256    = 1'b1;
  localparam logic [3:0] ID_VERSION    = 4'h5;
  localparam logic [2:0] ID_DENSITY    = 3'h4;
  localparam logic [2:0] ID_GENERATION = 3'h6;
  localparam logic [4:0] ID_VENDOR     = 5'h15;

  // ==========================================================
  // state machines
  // ==========================================================
  typedef enum logic [1:0]
  {
    PWR_RUN  = 2'b00,
    PWR_DPD  = 2'b01,
    PWR_INIT = 2'b10
  } psrcfg_pwr_type;

  typedef enum logic [1:0]
  {
    LAT_IDLE  = 2'b00,
    LAT_COUNT = 2'b01,
    LAT_DATA  = 2'b10
  } psrcfg_lat_type;

  // latency in clocks for a code; code zero means eight
  function automatic logic [3:0] psrcfg_lat_clocks(input logic [2:0] code,
                                                   input logic       fixed,
                                                   input logic       collision);
    logic [3:0] base;
    base = (code == 3'h0) ? LAT_CODE0_VAL : {1'b0, code};
    if (!fixed && collision)
      psrcfg_lat_clocks = {base[2:0], 1'b0};
    else
      psrcfg_lat_clocks = base;
  endfunction

endpackage

// >>> shared/psrcfg_lat_if.sv
`timescale 1ns/1ps
interface psrcfg_lat_if;
  logic       sync_mode;
  logic       fixed_lat;
  logic [2:0] lat_code;
  logic       wait_early;
  logic       wait_high;
  logic       burst_start;
  logic       burst_end;
  logic       collision;
  logic       wait_pin;
  logic       data_valid;

  modport cfg
  (
    output sync_mode, fixed_lat, lat_code, wait_early, wait_high,
    output burst_start, burst_end, collision,
    input  wait_pin, data_valid
  );

  modport lat
  (
    input  sync_mode, fixed_lat, lat_code, wait_early, wait_high,
    input  burst_start, burst_end, collision,
    output wait_pin, data_valid
  );
endinterface

// >>> design/psrcfg_latency.sv
`timescale 1ns/1ps
module psrcfg_latency
#(
  parameter int CNT_W = 4
)
(
  input  wire logic i_clk,
  input  wire logic i_rst_n,
  psrcfg_lat_if.lat lat_bus
);
  import psrcfg_pkg::*;

  // ==========================================================
  // parameter check
  // ==========================================================
  // a doubled latency of fourteen loads a count of thirteen, which needs four bits
  if (CNT_W < 4)
  begin : g_bad_width
    $error("psrcfg_latency: CNT_W must be at least 4");
  end

  // ==========================================================
  // burst latency sequencing
  // ==========================================================
  psrcfg_lat_type   state_q, state_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic             wait_act;
  logic             wait_pin_q;
  logic             data_valid_q;
  logic             data_valid_d;
  logic [3:0]       lat_clocks;

  // fixed mode ignores collision: its count already covers the worst case
  assign lat_clocks = psrcfg_lat_clocks(lat_bus.lat_code, lat_bus.fixed_lat,
                                        lat_bus.collision);

  // next state; burst end wins over state, data valid and wait, but not the count
  always_comb
  begin
    state_d      = state_q;
    cnt_d        = cnt_q;
    data_valid_d = 1'b0;
    wait_act     = 1'b0;
    case (state_q)
      LAT_IDLE:
      begin
        if (lat_bus.burst_start && lat_bus.sync_mode && !lat_bus.burst_end)
        begin
          state_d  = LAT_COUNT;
          cnt_d    = CNT_W'(lat_clocks - 4'h1);
          wait_act = 1'b1;
        end
      end
      LAT_COUNT:
      begin
        // early wait drops one clock ahead of data, late wait with it
        wait_act = lat_bus.wait_early ? (cnt_q > CNT_W'(1))
                                      : (cnt_q > CNT_W'(0));
        if (cnt_q == CNT_W'(0))
        begin
          state_d      = LAT_DATA;
          data_valid_d = 1'b1;
        end
        else
        begin
          cnt_d = cnt_q - CNT_W'(1);
        end
      end
      LAT_DATA:
      begin
        data_valid_d = 1'b1;
      end
      default:
      begin
        state_d = LAT_IDLE;
      end
    endcase
    if (lat_bus.burst_end)
    begin
      state_d      = LAT_IDLE;
      data_valid_d = 1'b0;
      wait_act     = 1'b0;
    end
  end

  // registered pin level, polarity applied here
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      state_q      <= LAT_IDLE;
      cnt_q        <= '0;
      wait_pin_q   <= 1'b0;
      data_valid_q <= 1'b0;
    end
    else
    begin
      state_q      <= state_d;
      cnt_q        <= cnt_d;
      wait_pin_q   <= lat_bus.wait_high ? wait_act : !wait_act;
      data_valid_q <= data_valid_d;
    end
  end

  assign lat_bus.wait_pin   = wait_pin_q;
  assign lat_bus.data_valid = data_valid_q;

endmodule

// >>> design/psrcfg_top.sv
`timescale 1ns/1ps
module psrcfg_top
#(
  parameter int INIT_WAIT_CYCLES = psrcfg_pkg::INIT_CYCLES,
  parameter int EXIT_CYCLES      = psrcfg_pkg::DPD_EXIT_CYCLES
)
(
  input  wire logic        i_core_clk,
  input  wire logic        i_resetn,
  input  wire logic        i_ce_n,
  input  wire logic        i_register_select_pin,
  input  wire logic [1:0]  i_reg_addr,
  input  wire logic        i_sw_seq,
  input  wire logic [15:0] i_sw_code,
  input  wire logic        i_cfg_wr,
  input  wire logic        i_cfg_rd,
  input  wire logic [15:0] i_cfg_wdata,
  input  wire logic        i_burst_start,
  input  wire logic        i_refresh_collision,
  output logic      [15:0] o_cfg_rdata,
  output logic             o_cfg_rvalid,
  output logic             o_wait,
  output logic             o_data_valid,
  output logic             o_sync_mode,
  output logic             o_deep_power_down,
  output logic             o_init_busy,
  output logic             o_refresh_enable,
  output logic      [20:0] o_refresh_first,
  output logic      [20:0] o_refresh_last
);
  import psrcfg_pkg::*;

  // ==========================================================
  // parameter checks
  // ==========================================================
  if (INIT_WAIT_CYCLES < 1 || INIT_WAIT_CYCLES >= 2**PWR_CNT_W)
  begin : g_bad_init
    $error("psrcfg_top: INIT_WAIT_CYCLES out of counter range");
  end
  if (EXIT_CYCLES < 1 || EXIT_CYCLES >= 2**PWR_CNT_W)
  begin : g_bad_exit
    $error("psrcfg_top: EXIT_CYCLES out of counter range");
  end

  localparam logic [PWR_CNT_W-1:0] INIT_LAST = PWR_CNT_W'(INIT_WAIT_CYCLES - 1);
  localparam logic [PWR_CNT_W-1:0] EXIT_LAST = PWR_CNT_W'(EXIT_CYCLES - 1);

  // ==========================================================
  // reset release
  // ==========================================================
  logic rst_meta_q;
  logic rst_n_q;

  // release is synchronised so no flop sees a partial edge
  always_ff @(posedge i_core_clk or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      rst_meta_q <= 1'b0;
      rst_n_q    <= 1'b0;
    end
    else
    begin
      rst_meta_q <= 1'b1;
      rst_n_q    <= rst_meta_q;
    end
  end

  // ==========================================================
  // partial refresh decoding
  // ==========================================================
  // region start for a partial refresh code
  function automatic logic [20:0] psrcfg_par_first(input logic [2:0] par);
    case (par)
      3'h5:    psrcfg_par_first = 21'h100000;
      3'h6:    psrcfg_par_first = 21'h180000;
      3'h7:    psrcfg_par_first = 21'h1C0000;
      default: psrcfg_par_first = 21'h000000;
    endcase
  endfunction

  // region end for a partial refresh code
  function automatic logic [20:0] psrcfg_par_last(input logic [2:0] par);
    case (par)
      3'h1:    psrcfg_par_last = 21'h0FFFFF;
      3'h2:    psrcfg_par_last = 21'h07FFFF;
      3'h3:    psrcfg_par_last = 21'h03FFFF;
      3'h4:    psrcfg_par_last = 21'h000000;
      default: psrcfg_par_last = ARRAY_LAST;
    endcase
  endfunction

  // ==========================================================
  // register selection
  // ==========================================================
  wire sel_refresh;
  wire sel_ident;
  wire sel_bus;

  // the select pin takes priority over the software sequence
  assign sel_refresh = i_register_select_pin ? (i_reg_addr == SEL_REFRESH)
                       : (i_sw_seq && i_sw_code == SW_CODE_REFRESH);
  assign sel_ident   = i_register_select_pin ? (i_reg_addr == SEL_IDENT)
                       : (i_sw_seq && i_sw_code == SW_CODE_IDENT);
  assign sel_bus     = i_register_select_pin ? (i_reg_addr == SEL_BUS)
                       : (i_sw_seq && i_sw_code == SW_CODE_BUS);

  // ==========================================================
  // power state machine
  // ==========================================================
  psrcfg_pwr_type       pwr_q, pwr_d;
  logic [PWR_CNT_W-1:0] pcnt_q, pcnt_d;
  logic                 dpd_exit;
  logic [15:0]          bus_cfg_q, bus_cfg_d;
  logic [15:0]          refresh_cfg_q, refresh_cfg_d;
  wire                  cfg_open;

  // registers are only writable in normal operation
  assign cfg_open = (pwr_q == PWR_RUN);

  always_comb
  begin
    pwr_d    = pwr_q;
    pcnt_d   = pcnt_q;
    dpd_exit = 1'b0;
    case (pwr_q)
      PWR_RUN:
      begin
        if (!refresh_cfg_q[REFRESH_PWR_BIT] && i_ce_n)
        begin
          pwr_d  = PWR_DPD;
          pcnt_d = '0;
        end
      end
      PWR_DPD:
      begin
        // any high on chip select restarts the low-time measurement
        if (i_ce_n)
          pcnt_d = '0;
        else if (pcnt_q == EXIT_LAST)
        begin
          pwr_d    = PWR_INIT;
          pcnt_d   = '0;
          dpd_exit = 1'b1;
        end
        else
          pcnt_d = pcnt_q + PWR_CNT_W'(1);
      end
      PWR_INIT:
      begin
        if (pcnt_q == INIT_LAST)
          pwr_d = PWR_RUN;
        else
          pcnt_d = pcnt_q + PWR_CNT_W'(1);
      end
      default:
      begin
        pwr_d  = PWR_RUN;
        pcnt_d = '0;
      end
    endcase
  end

  // ==========================================================
  // configuration registers
  // ==========================================================
  // hardware restore on exit wins over a same-cycle write
  always_comb
  begin
    bus_cfg_d     = bus_cfg_q;
    refresh_cfg_d = refresh_cfg_q;
    if (i_cfg_wr && cfg_open && sel_bus)
      bus_cfg_d = i_cfg_wdata;
    if (i_cfg_wr && cfg_open && sel_refresh)
      refresh_cfg_d = i_cfg_wdata;
    if (dpd_exit)
    begin
      bus_cfg_d[BUS_DRIVE_BIT]       = BUS_CFG_RESET[BUS_DRIVE_BIT];
      refresh_cfg_d[REFRESH_PWR_BIT] = 1'b1;
    end
  end

  wire [15:0] ident_word;
  wire [15:0] read_mux;

  // constant word; no write path exists, so writes fall away
  assign ident_word = {ID_ROW_256, ID_VERSION, ID_DENSITY,
                       ID_GENERATION, ID_VENDOR};
  assign read_mux   = sel_refresh ? refresh_cfg_q :
                      sel_ident   ? ident_word    :
                      sel_bus     ? bus_cfg_q     : 16'h0000;

  always_ff @(posedge i_core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      pwr_q         <= PWR_RUN;
      pcnt_q        <= '0;
      bus_cfg_q     <= BUS_CFG_RESET;
      refresh_cfg_q <= REFRESH_CFG_RESET;
    end
    else
    begin
      pwr_q         <= pwr_d;
      pcnt_q        <= pcnt_d;
      bus_cfg_q     <= bus_cfg_d;
      refresh_cfg_q <= refresh_cfg_d;
    end
  end

  // ==========================================================
  // read port and status outputs
  // ==========================================================
  logic [15:0] rdata_q;
  logic        rvalid_q;
  logic        sync_q;
  logic        dpd_q;
  logic        init_q;
  logic        ref_en_q;
  logic [20:0] ref_first_q;
  logic [20:0] ref_last_q;

  // status follows next state so outputs track the machine without lag
  always_ff @(posedge i_core_clk or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      rdata_q     <= 16'h0000;
      rvalid_q    <= 1'b0;
      sync_q      <= 1'b0;
      dpd_q       <= 1'b0;
      init_q      <= 1'b0;
      ref_en_q    <= 1'b1;
      ref_first_q <= 21'h000000;
      ref_last_q  <= ARRAY_LAST;
    end
    else
    begin
      rvalid_q    <= i_cfg_rd && cfg_open;
      if (i_cfg_rd && cfg_open)
        rdata_q <= read_mux;
      sync_q      <= (bus_cfg_d[BUS_MODE_BIT] != MODE_ASYNC);
      dpd_q       <= (pwr_d == PWR_DPD);
      init_q      <= (pwr_d == PWR_INIT);
      ref_en_q    <= (pwr_d != PWR_DPD)
                     && (refresh_cfg_d[PAR_MSB:0] != 3'h4);
      ref_first_q <= psrcfg_par_first(refresh_cfg_d[PAR_MSB:0]);
      ref_last_q  <= psrcfg_par_last(refresh_cfg_d[PAR_MSB:0]);
    end
  end

  // ==========================================================
  // burst latency and wait
  // ==========================================================
  psrcfg_lat_if lat_link ();

  // bursts only in synchronous mode and normal operation
  assign lat_link.sync_mode   = sync_q;
  assign lat_link.fixed_lat   = bus_cfg_q[BUS_LAT_FIXED];
  assign lat_link.lat_code    = bus_cfg_q[BUS_LAT_MSB:BUS_LAT_LSB];
  assign lat_link.wait_early  = bus_cfg_q[BUS_WAIT_EARLY];
  assign lat_link.wait_high   = bus_cfg_q[BUS_WAIT_POL];
  assign lat_link.burst_start = i_burst_start && cfg_open && !i_register_select_pin;
  assign lat_link.burst_end   = i_ce_n;
  assign lat_link.collision   = i_refresh_collision;

  psrcfg_latency
  #(
    .CNT_W (4)
  )
  u_latency
  (
    .i_clk   (i_core_clk),
    .i_rst_n (rst_n_q),
    .lat_bus (lat_link)
  );

  assign o_cfg_rdata       = rdata_q;
  assign o_cfg_rvalid      = rvalid_q;
  assign o_wait            = lat_link.wait_pin;
  assign o_data_valid      = lat_link.data_valid;
  assign o_sync_mode       = sync_q;
  assign o_deep_power_down = dpd_q;
  assign o_init_busy       = init_q;
  assign o_refresh_enable  = ref_en_q;
  assign o_refresh_first   = ref_first_q;
  assign o_refresh_last    = ref_last_q;

endmodule

// >>> test/psrcfg_monitor.sv
`timescale 1ns/1ps
module psrcfg_monitor
  import psrcfg_pkg::*;
#(
  parameter int INIT_WAIT_CYCLES = 20,
  parameter int EXIT_CYCLES      = 8
)
(
  input wire logic        i_core_clk,
  input wire logic        i_resetn,
  input wire logic        i_ce_n,
  input wire logic        i_register_select_pin,
  input wire logic [1:0]  i_reg_addr,
  input wire logic        i_sw_seq,
  input wire logic [15:0] i_sw_code,
  input wire logic        i_cfg_wr,
  input wire logic        i_cfg_rd,
  input wire logic [15:0] i_cfg_wdata,
  input wire logic        i_burst_start,
  input wire logic        i_refresh_collision,
  input wire logic [15:0] o_cfg_rdata,
  input wire logic        o_cfg_rvalid,
  input wire logic        o_wait,
  input wire logic        o_data_valid,
  input wire logic        o_sync_mode,
  input wire logic        o_deep_power_down,
  input wire logic        o_init_busy,
  input wire logic        o_refresh_enable,
  input wire logic [20:0] o_refresh_first,
  input wire logic [20:0] o_refresh_last
);
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  // ==========================================================
  // helper counters: low time in power-down, length of init
  // ==========================================================
  logic [15:0] low_q;
  logic [15:0] init_q;
  wire         id_sel = i_cfg_rd && i_register_select_pin && i_reg_addr == SEL_IDENT;

  // counts consecutive chip-select-low cycles while powered down
  always_ff @(posedge i_core_clk or negedge i_resetn)
    if (!i_resetn)
      low_q <= 16'h0000;
    else
      low_q <= (o_deep_power_down && !i_ce_n) ? low_q + 16'h0001 : 16'h0000;

  // counts cycles of the init window
  always_ff @(posedge i_core_clk or negedge i_resetn)
    if (!i_resetn)
      init_q <= 16'h0000;
    else
      init_q <= o_init_busy ? init_q + 16'h0001 : 16'h0000;

  // ==========================================================
  // assertions
  // ==========================================================
  rd_answer_a: assert property (i_cfg_rd && !o_deep_power_down && !o_init_busy |=> o_cfg_rvalid)
    else $error("read not answered");
  rd_refused_a: assert property ((o_deep_power_down || o_init_busy) && i_cfg_rd |=> !o_cfg_rvalid)
    else $error("read answered while powered down");
  ident_value_a: assert property (o_cfg_rvalid && $past(id_sel) |-> o_cfg_rdata == {ID_ROW_256, ID_VERSION, ID_DENSITY, ID_GENERATION, ID_VENDOR})
    else $error("identification value wrong");
  rdata_hold_a: assert property (!o_cfg_rvalid |-> $stable(o_cfg_rdata))
    else $error("read data moved without answer");
  dv_end_a: assert property (o_data_valid && i_ce_n |=> !o_data_valid)
    else $error("data valid outlived chip select");
  dpd_norefresh_a: assert property (o_deep_power_down && $past(o_deep_power_down) |-> !o_refresh_enable)
    else $error("refresh running in power-down");
  exit_len_a: assert property (low_q <= EXIT_CYCLES + 2)
    else $error("power-down exit late");
  init_len_a: assert property ($fell(o_init_busy) |-> init_q >= INIT_WAIT_CYCLES - 1 && init_q <= INIT_WAIT_CYCLES + 1)
    else $error("init window length wrong");

  // main scenarios reached
  cover property ($rose(o_data_valid));
  cover property ($rose(o_deep_power_down));
  cover property ($fell(o_init_busy));
endmodule

bind psrcfg_top psrcfg_monitor #(.INIT_WAIT_CYCLES(INIT_WAIT_CYCLES), .EXIT_CYCLES(EXIT_CYCLES)) mon
(
  .i_core_clk, .i_resetn, .i_ce_n, .i_register_select_pin, .i_reg_addr, .i_sw_seq, .i_sw_code,
  .i_cfg_wr, .i_cfg_rd, .i_cfg_wdata, .i_burst_start, .i_refresh_collision, .o_cfg_rdata,
  .o_cfg_rvalid, .o_wait, .o_data_valid, .o_sync_mode, .o_deep_power_down, .o_init_busy,
  .o_refresh_enable, .o_refresh_first, .o_refresh_last
);

// >>> test/psrcfg_ctrl_model.sv
`timescale 1ns/1ps
module psrcfg_ctrl_model
(
  input  wire logic        i_core_clk,
  input  wire logic        i_wait,
  input  wire logic        i_data_valid,
  input  wire logic        i_cfg_rvalid,
  input  wire logic [15:0] i_cfg_rdata,
  output logic             o_ce_n,
  output logic             o_sel,
  output logic      [1:0]  o_addr,
  output logic             o_sw_seq,
  output logic      [15:0] o_sw_code,
  output logic             o_wr,
  output logic             o_rd,
  output logic      [15:0] o_wdata,
  output logic             o_start,
  output logic             o_coll
);
  // ==========================================================
  // idle levels; chip select idles high
  // ==========================================================
  initial
  begin
    {o_ce_n, o_sel, o_addr, o_sw_seq, o_sw_code} = {1'b1, 1'b0, 2'b11, 1'b0, 16'hFFFF};
    {o_wr, o_rd, o_wdata, o_start, o_coll} = {1'b0, 1'b0, 16'hA5A5, 1'b0, 1'b0};
  end

  // one register access; select by pin or by sequence code
  task automatic acc(input logic w, input logic p, input logic [1:0] a, input logic [15:0] c,
                     input logic [15:0] wd, output logic ok, output logic [15:0] d);
    @(negedge i_core_clk);
    {o_sel, o_sw_seq, o_addr, o_sw_code, o_wdata, o_wr, o_rd} = {p, !p, a, c, wd, w, !w};
    @(negedge i_core_clk);
    // the answer stands only in the cycle after the strobe edge
    ok = i_cfg_rvalid;
    d = i_cfg_rdata;
    // released address, code and data show the inverse; select and strobe lines drop low
    {o_sel, o_sw_seq, o_addr, o_sw_code, o_wdata, o_wr, o_rd} = {2'b00, ~a, ~c, ~wd, 2'b00};
    @(negedge i_core_clk);
  endtask

  // burst start; measures first data and last asserted wait cycle
  task automatic burst(input logic co, input logic pol, output int dv, output int wt);
    @(negedge i_core_clk);
    {o_ce_n, o_start, o_coll} = {1'b0, 1'b1, co};
    dv = 0;
    wt = 0;
    for (int k = 1; k <= 20 && dv == 0; k++)
    begin
      @(negedge i_core_clk);
      {o_start, o_coll} = {1'b0, ~co};
      if (i_wait === pol)
        wt = k;
      if (i_data_valid === 1'b1)
        dv = k;
    end
    o_ce_n = 1'b1;
    @(negedge i_core_clk);
  endtask

  // chip select level for power-down entry and exit
  task automatic ce(input logic v);
    @(negedge i_core_clk);
    o_ce_n = v;
  endtask
endmodule

// >>> test/pseudo_sram_config_regs_bench.sv
`timescale 1ns/1ps
module pseudo_sram_config_regs_bench;
  import psrcfg_pkg::*;
  localparam int          EXIT   = 8;
  localparam int          INIT   = 20;
  localparam logic [15:0] ID_EXP = {ID_ROW_256, ID_VERSION, ID_DENSITY, ID_GENERATION, ID_VENDOR};
  localparam logic [2:0]  CODES [8] = '{3'h2, 3'h3, 3'h4, 3'h3, 3'h4, 3'h5, 3'h6, 3'h0};

  logic        i_core_clk;
  logic        i_resetn;
  logic        ce_n, sel, swq, wr, rd, st, co, rvalid, wt, dv, sm, deep_power_down, ib, re;
  logic [1:0]  addr;
  logic [15:0] swc, wd, rdata;
  logic [20:0] rf, rl;
  int          err_count = 0;
  int          n_tests = 0;
  int          cyc = 0;

  psrcfg_top #(.INIT_WAIT_CYCLES(INIT), .EXIT_CYCLES(EXIT)) uut
  (
    .i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_ce_n(ce_n), .i_register_select_pin(sel),
    .i_reg_addr(addr), .i_sw_seq(swq), .i_sw_code(swc), .i_cfg_wr(wr), .i_cfg_rd(rd),
    .i_cfg_wdata(wd), .i_burst_start(st), .i_refresh_collision(co), .o_cfg_rdata(rdata),
    .o_cfg_rvalid(rvalid), .o_wait(wt), .o_data_valid(dv), .o_sync_mode(sm),
    .o_deep_power_down(deep_power_down), .o_init_busy(ib), .o_refresh_enable(re),
    .o_refresh_first(rf), .o_refresh_last(rl)
  );

  psrcfg_ctrl_model m
  (
    .i_core_clk(i_core_clk), .i_wait(wt), .i_data_valid(dv), .i_cfg_rvalid(rvalid),
    .i_cfg_rdata(rdata), .o_ce_n(ce_n), .o_sel(sel), .o_addr(addr), .o_sw_seq(swq),
    .o_sw_code(swc), .o_wr(wr), .o_rd(rd), .o_wdata(wd), .o_start(st), .o_coll(co)
  );

  // ==========================================================
  // clock, hang guard, checking helpers
  // ==========================================================
  initial
  begin
    i_core_clk = 1'b0;
    forever #12.5 i_core_clk = ~i_core_clk;
  end

  // the run needs well under a thousand cycles
  always @(posedge i_core_clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      err_count++;
      results();
    end
  end

  task automatic results;
    $display("checks %0d errors %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [20:0] got, input logic [20:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("ERROR %0t got %0h expected %0h", $time, got, exp);
    end
  endtask

  task automatic rreg(input logic p, input logic [1:0] a, input logic [15:0] c,
                      input logic [15:0] e);
    logic        ok;
    logic [15:0] d;
    m.acc(1'b0, p, a, c, 16'h0000, ok, d);
    chk(21'(ok), 21'h000001);
    chk(21'(d), 21'(e));
  endtask

  task automatic wreg(input logic p, input logic [1:0] a, input logic [15:0] c,
                      input logic [15:0] v);
    logic        ok;
    logic [15:0] d;
    m.acc(1'b1, p, a, c, v, ok, d);
  endtask

  // expected refreshed region {first, last} for a partial code
  function automatic logic [41:0] region(input logic [2:0] c);
    logic [20:0] sz;
    sz = ARRAY_LAST >> c[1:0];
    region = c[2] ? {ARRAY_LAST - sz, ARRAY_LAST} : {21'h000000, sz};
  endfunction

  // clocks to first data for a latency setting
  function automatic int lat(input logic [2:0] c, input logic f, input logic cl);
    lat = (c == 3'h0) ? 8 : int'(c);
    if (!f && cl)
      lat = lat * 2;
  endfunction

  // ==========================================================
  // main sequence
  // ==========================================================
  initial
  begin
    logic        ok, f, cl, e, p;
    logic [2:0]  c;
    logic [15:0] d, v;
    int          gd, gw, n, k, r;
    void'($urandom(62));
    i_resetn = 1'b0;
    repeat (16) @(negedge i_core_clk);
    i_resetn = 1'b1;
    repeat (3) @(negedge i_core_clk);
    // reset values, pin and sequence selection, unmapped place
    rreg(1'b1, SEL_REFRESH, 16'h0000, REFRESH_CFG_RESET);
    rreg(1'b1, SEL_BUS, 16'h0000, BUS_CFG_RESET);
    chk(21'(sm), 21'h000000);
    rreg(1'b1, SEL_IDENT, 16'h0000, ID_EXP);
    rreg(1'b1, 2'b11, 16'h0000, 16'h0000);
    rreg(1'b0, 2'b11, SW_CODE_REFRESH, REFRESH_CFG_RESET);
    // identification ignores writes by pin and by sequence
    wreg(1'b1, SEL_IDENT, 16'h0000, 16'($urandom));
    wreg(1'b0, 2'b11, SW_CODE_IDENT, 16'($urandom));
    rreg(1'b0, 2'b11, SW_CODE_IDENT, ID_EXP);
    // asynchronous mode gives no burst data
    m.burst(1'b0, 1'b1, gd, gw);
    chk(21'(gd), 21'h000000);
    // every partial refresh code, random starting point
    r = $urandom % 8;
    for (k = 0; k < 8; k++)
    begin
      c = 3'(k + r);
      v = {11'h000, 1'b1, 1'b0, c};
      wreg(1'b1, SEL_REFRESH, 16'h0000, v);
      rreg(1'b0, 2'b11, SW_CODE_REFRESH, v);
      chk(rf, c == 3'h4 ? 21'h000000 : region(c)[41:21]);
      chk(rl, c == 3'h4 ? 21'h000000 : region(c)[20:0]);
      chk(21'(re), 21'(c != 3'h4));
    end
    // latency table: variable then fixed codes usable at this clock
    for (k = 0; k < 8; k++)
    begin
      f = (k >= 3);
      c = CODES[k];
      cl = 1'($urandom);
      e = 1'($urandom);
      p = 1'($urandom);
      v = {1'b0, f, c, p, 1'b0, e, 8'h1F};
      wreg(k[0], SEL_BUS, SW_CODE_BUS, v);
      chk(21'(sm), 21'h000001);
      m.burst(cl, p, gd, gw);
      n = lat(c, f, cl);
      // first sample after the start edge counts as one; data follows the count
      chk(21'(gd), 21'(n + 1));
      chk(21'(gw), 21'(e ? n - 1 : n));
      chk({19'h00000, wt, dv}, {19'h00000, !p, 1'b0});
    end
    // deep power-down with non-default contents, then exit
    wreg(1'b1, SEL_BUS, 16'h0000, 16'h1D0F);
    wreg(1'b1, SEL_REFRESH, 16'h0000, 16'h0003);
    @(negedge i_core_clk);
    chk({19'h00000, deep_power_down, re}, 21'h000002);
    m.acc(1'b0, 1'b1, SEL_REFRESH, 16'h0000, 16'h0000, ok, d);
    chk(21'(ok), 21'h000000);
    m.ce(1'b0);
    repeat (EXIT - 3) @(negedge i_core_clk);
    chk(21'(deep_power_down), 21'h000001);
    repeat (6) @(negedge i_core_clk);
    chk({19'h00000, deep_power_down, ib}, 21'h000001);
    m.ce(1'b1);
    m.acc(1'b0, 1'b1, SEL_REFRESH, 16'h0000, 16'h0000, ok, d);
    chk(21'(ok), 21'h000000);
    repeat (INIT - 12) @(negedge i_core_clk);
    chk(21'(ib), 21'h000001);
    for (k = 0; k < 20 && ib !== 1'b0; k++)
      @(negedge i_core_clk);
    chk(21'(ib), 21'h000000);
    rreg(1'b1, SEL_REFRESH, 16'h0000, 16'h0013);
    rreg(1'b1, SEL_BUS, 16'h0000, 16'h1D1F);
    results();
  end
endmodule
